// ---- hw/rrs_core.sv ----
module rrs_core
  import rrs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Instruction in
  input wire logic insnValid,
  input wire logic [INSN_W-1:0] insn,
  input wire logic [PC_W-1:0] pcPlusOne,
  // Call push from the rest of the core
  input wire logic callPush,
  // Register file read of the addressed location
  input wire logic [7:0] fileData,
  // Wake event from outside
  input wire logic wake,
  // Results
  output logic [7:0] acc,
  output rrs_status_t status,
  output rrs_fwrite_t fileWrite,
  output logic pcLoad,
  output logic [PC_W-1:0] pcValue,
  output logic wdogClear,
  output logic oscStop,
  output logic insnReady
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  function automatic logic opMatch(input logic [13:0] w, input logic [13:0] m,
                                   input logic [13:0] v);
    return (w & m) == v;
  endfunction

  rrs_state_t state;
  rrs_state_t next_state;
  wire logic take = insnValid && insnReady;
  wire logic isRetLit = take && opMatch(insn, MASK_RETLIT, MATCH_RETLIT);
  wire logic isReturn = take && (insn == OP_RETURN);
  wire logic isRotr = take && opMatch(insn, MASK_ROTR, MATCH_ROTR);
  wire logic isSleep = take && (insn == OP_SLEEP);
  wire logic isLitSub = take && opMatch(insn, MASK_LITSUB, MATCH_LITSUB);
  wire logic isLitXor = take && opMatch(insn, MASK_LITXOR, MATCH_LITXOR);
  wire logic [7:0] lit = insn[7:0];
  wire logic destFile = insn[DEST_BIT];
  wire logic anyReturn = isRetLit || isReturn;

  ////////////////////////////////////////////////////////////////////////////
  // Datapaths
  // Rotate: old carry into bit 7, bit 0 out to carry
  wire logic [7:0] rotResult = {status.carry, fileData[7:1]};
  wire logic rotCarry = fileData[0];
  // Subtract by adding the complement plus one; carry out means no borrow
  wire logic [8:0] subSum = {1'b0, lit} + {1'b0, ~acc} + 9'h001;
  wire logic [4:0] subLow = {1'b0, lit[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
  wire logic [7:0] xorResult = acc ^ lit;

  // Stack head, held in a small memory of its own
  logic [PC_W-1:0] stackHead;
  rrs_stack_mem rrs_stack_mem_i (
    .clk(clk),
    .rst_n(rst_n),
    .push(callPush),
    .pop(anyReturn),
    .pushData(pcPlusOne),
    .stackHead(stackHead)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: flush cycle after returns, halt after sleep
  always_comb begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (isSleep) begin
          next_state = ST_HALT;
        end else if (anyReturn) begin
          next_state = ST_FLUSH;
        end
      end
      ST_FLUSH: next_state = ST_RUN;
      ST_HALT: begin
        if (wake) begin
          next_state = ST_RUN;
        end
      end
      default: next_state = ST_RUN;
    endcase
  end

  assign insnReady = (state == ST_RUN);
  assign oscStop = (state == ST_HALT);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator
  logic [7:0] next_acc;
  always_comb begin
    next_acc = acc;
    if (isRetLit) begin
      next_acc = lit;
    end else if (isRotr && !destFile) begin
      next_acc = rotResult;
    end else if (isLitSub) begin
      next_acc = subSum[7:0];
    end else if (isLitXor) begin
      next_acc = xorResult;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc <= RST_ACC;
    end else begin
      acc <= next_acc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags; returns leave them alone
  rrs_status_t next_status;
  always_comb begin
    next_status = status;
    if (isRotr) begin
      next_status.carry = rotCarry;
    end
    if (isLitSub) begin
      next_status.carry = subSum[8];
      next_status.halfCarry = subLow[NIBBLE_W];
      next_status.zero = (subSum[7:0] == 8'h00);
    end
    if (isLitXor) begin
      next_status.zero = (xorResult == 8'h00);
    end
    if (isSleep) begin
      next_status.powerdown = 1'b0;
      next_status.expiry = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= '{RST_CARRY, RST_HALF, RST_ZERO, RST_EXPIRY, RST_PDOWN};
    end else begin
      status <= next_status;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered side outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fileWrite <= '0;
      pcLoad <= 1'b0;
      pcValue <= '0;
      wdogClear <= 1'b0;
    end else begin
      fileWrite <= '{isRotr && destFile, insn[6:0], rotResult};
      pcLoad <= anyReturn;
      pcValue <= anyReturn ? stackHead : pcValue;
      wdogClear <= isSleep;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence seqReturnTaken;
    isRetLit || isReturn;
  endsequence

  sequence seqFlushThenRun;
    !insnReady ##1 insnReady;
  endsequence

  chk_ret_two_cycles: assert property (@(posedge clk) disable iff (!rst_n)
    seqReturnTaken |=> seqFlushThenRun)
    else $error("return did not take two cycles");

  chk_retlit_acc: assert property (@(posedge clk) disable iff (!rst_n)
    isRetLit |=> (acc == $past(insn[7:0])) && pcLoad)
    else $error("return literal did not load accumulator");

  chk_ret_flags_kept: assert property (@(posedge clk) disable iff (!rst_n)
    seqReturnTaken |=> status == $past(status))
    else $error("return changed status");

  chk_rot_result: assert property (@(posedge clk) disable iff (!rst_n)
    isRotr && !destFile |=>
      acc == {$past(status.carry), $past(fileData[7:1])} && status.carry == $past(fileData[0]))
    else $error("rotate result wrong");

  chk_rot_dest: assert property (@(posedge clk) disable iff (!rst_n)
    isRotr |=> fileWrite.en == $past(destFile) && (!fileWrite.en || (acc == $past(acc)
      && fileWrite.data == {$past(status.carry), $past(fileData[7:1])}
      && fileWrite.addr == $past(insn[6:0]))))
    else $error("rotate destination wrong");

  chk_sleep_wdog: assert property (@(posedge clk) disable iff (!rst_n)
    isSleep |=> wdogClear ##1 !wdogClear)
    else $error("watchdog clear not one pulse");

  chk_sleep_flags: assert property (@(posedge clk) disable iff (!rst_n)
    isSleep |=> !status.powerdown && status.expiry && status.carry == $past(status.carry))
    else $error("halt flags wrong");

  chk_halt_holds: assert property (@(posedge clk) disable iff (!rst_n)
    oscStop && !wake |=> oscStop && !insnReady)
    else $error("halt left without wake");

  chk_sub_flags: assert property (@(posedge clk) disable iff (!rst_n)
    isLitSub |=> status.carry == ($past(insn[7:0]) >= $past(acc))
      && status.halfCarry == ($past(insn[3:0]) >= $past(acc[3:0]))
      && acc == 8'($past(insn[7:0]) - $past(acc))
      && status.zero == (acc == 8'h00))
    else $error("subtract flags wrong");

  chk_xor_result: assert property (@(posedge clk) disable iff (!rst_n)
    isLitXor |=> acc == ($past(acc) ^ $past(insn[7:0])) && status.carry == $past(status.carry))
    else $error("xor result wrong");

endmodule

// ---- hw/rrs_pkg.sv ----
package rrs_pkg;

  // Instruction word is 14 bits wide
  localparam int unsigned INSN_W = 14;
  localparam int unsigned PC_W = 13;
  localparam int unsigned STACK_DEPTH = 8;
  localparam int unsigned STACK_PTR_W = 3;

  // Fixed opcodes
  localparam logic [13:0] OP_RETURN = 14'h0008;
  localparam logic [13:0] OP_SLEEP = 14'h0063;
  // Opcode masks and matches for operand-carrying forms
  localparam logic [13:0] MASK_RETLIT = 14'h3C00;
  localparam logic [13:0] MATCH_RETLIT = 14'h3400;
  localparam logic [13:0] MASK_ROTR = 14'h3F00;
  localparam logic [13:0] MATCH_ROTR = 14'h0C00;
  localparam logic [13:0] MASK_LITSUB = 14'h3E00;
  localparam logic [13:0] MATCH_LITSUB = 14'h3C00;
  localparam logic [13:0] MASK_LITXOR = 14'h3F00;
  localparam logic [13:0] MATCH_LITXOR = 14'h3A00;

  // Field positions
  localparam int unsigned DEST_BIT = 7;
  localparam int unsigned NIBBLE_W = 4;

  // Watchdog clear values
  localparam logic [7:0] WDOG_CLEAR = 8'h00;

  // Reset values of the held status and the accumulator
  localparam logic RST_CARRY = 1'b0;
  localparam logic RST_HALF = 1'b0;
  localparam logic RST_ZERO = 1'b0;
  localparam logic RST_EXPIRY = 1'b1;
  localparam logic RST_PDOWN = 1'b1;
  localparam logic [7:0] RST_ACC = 8'h00;

  // Returns take two cycles
  localparam int unsigned RET_CYCLES = 2;

  // Status flag group
  typedef struct packed {
    logic carry;
    logic halfCarry;
    logic zero;
    logic expiry;
    logic powerdown;
  } rrs_status_t;

  // Register file write request
  typedef struct packed {
    logic en;
    logic [6:0] addr;
    logic [7:0] data;
  } rrs_fwrite_t;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_FLUSH,
    ST_HALT
  } rrs_state_t;

endpackage

// ---- hw/rrs_stack_mem.sv ----
module rrs_stack_mem
  import rrs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Push and pop
  input wire logic push,
  input wire logic pop,
  input wire logic [PC_W-1:0] pushData,
  // Registered head of stack
  output logic [PC_W-1:0] stackHead
);

  // Circular storage, no overflow detection as on the real stack
  logic [PC_W-1:0] mem [STACK_DEPTH];
  logic [STACK_PTR_W-1:0] ptr;
  wire [STACK_PTR_W-1:0] next_ptr = push ? ptr + 3'h1 : (pop ? ptr - 3'h1 : ptr);
  wire [STACK_PTR_W-1:0] headIdx = next_ptr - 3'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Pointer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr <= '0;
    end else begin
      ptr <= next_ptr;
    end
  end

  // Storage, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem[ptr] <= pushData;
    end
  end

  // Registered head; a push the same cycle is forwarded
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stackHead <= '0;
    end else if (push) begin
      stackHead <= pushData;
    end else begin
      stackHead <= mem[headIdx];
    end
  end

endmodule

// ---- dv/tb_rrs_core.sv ----
module tb_rrs_core
  import rrs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // Clock, reset and design inputs
  logic clk, rst_n, insnValid, callPush, wake;
  logic [INSN_W-1:0] insn;
  logic [PC_W-1:0] pcPlusOne;
  logic [7:0] fileData;
  // Design outputs
  logic [7:0] acc;
  rrs_status_t status;
  rrs_fwrite_t fileWrite;
  logic pcLoad, wdogClear, oscStop, insnReady;
  logic [PC_W-1:0] pcValue;
  // Reference model state
  logic [7:0] mAcc;
  logic mC, mH, mZ, mE, mP;
  logic [PC_W-1:0] stk[$];
  logic [31:0] seed = 32'h000019FE;
  int miscompares = 0;
  int tests_run = 0;

  rrs_core rrs_core_i (.clk(clk), .rst_n(rst_n), .insnValid(insnValid), .insn(insn),
    .pcPlusOne(pcPlusOne), .callPush(callPush), .fileData(fileData), .wake(wake), .acc(acc),
    .status(status), .fileWrite(fileWrite), .pcLoad(pcLoad), .pcValue(pcValue),
    .wdogClear(wdogClear), .oscStop(oscStop), .insnReady(insnReady));

  ////////////////////////////////////////////////////////////////////////////////
  // Free running 4 ns clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Xorshift source, fixed start so a failure replays exactly
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Count and report one comparison
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // Compare the accumulator, status, file write and both pulses with the model
  task automatic cmpAll(input logic [15:0] fw, input logic wd, input logic pl, input string msg);
    logic [15:0] fwSeen;
    // Address and data of a file write only mean something while its enable is up
    fwSeen = {fileWrite.en, fw[15] ? {fileWrite.addr, fileWrite.data} : 15'h0000};
    check({8'h00, acc}, {8'h00, mAcc}, {msg, " acc"});
    check({11'h000, status}, {11'h000, mC, mH, mZ, mE, mP}, {msg, " status"});
    check(fwSeen, fw, {msg, " file write"});
    check({14'h0000, wdogClear, pcLoad}, {14'h0000, wd, pl}, {msg, " pulses"});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Offer a word at the falling edge; valid is left up so ops can run back to back
  task automatic issue(input logic [13:0] w, input logic [7:0] f);
    insn = w;
    fileData = f;
    insnValid = 1'b1;
    @(negedge clk);
  endtask

  // Push a return address; valid drops first so nothing is taken twice
  task automatic push(input logic [PC_W-1:0] a);
    insnValid = 1'b0;
    pcPlusOne = a;
    callPush = 1'b1;
    @(negedge clk);
    callPush = 1'b0;
    stk.push_back(a);
  endtask

  // One instruction of the given kind, literal random unless forced
  task automatic doOp(input int kind, input bit force_k, input logic [7:0] kf);
    logic [31:0] r;
    logic [7:0] k, res;
    logic [PC_W-1:0] head;
    r = rnd();
    k = force_k ? kf : r[7:0];
    if (kind >= 3 && kind <= 4 && stk.size() == 0) push(r[20:8]);
    case (kind)
      0: begin
        issue(14'h3A00 | {6'h00, k}, r[31:24]);
        mAcc ^= k;
        mZ = (mAcc == 8'h00);
        cmpAll(16'h0000, 1'b0, 1'b0, "xor");
      end
      1: begin
        issue(14'h3C00 | {5'h00, r[8], k}, r[31:24]);
        mC = (k >= mAcc);
        mH = (k[3:0] >= mAcc[3:0]);
        mAcc = k - mAcc;
        mZ = (mAcc == 8'h00);
        cmpAll(16'h0000, 1'b0, 1'b0, "subtract");
      end
      2: begin
        issue(14'h0C00 | {6'h00, r[15:8]}, k);
        res = {mC, k[7:1]};
        mC = k[0];
        if (r[15]) cmpAll({1'b1, r[14:8], res}, 1'b0, 1'b0, "rotate file");
        else begin
          mAcc = res;
          cmpAll(16'h0000, 1'b0, 1'b0, "rotate acc");
        end
      end
      3, 4: begin
        head = stk.pop_back();
        issue(kind == 3 ? (14'h3400 | {4'h0, r[9:8], k}) : OP_RETURN, r[31:24]);
        insnValid = 1'b0;
        if (kind == 3) mAcc = k;
        cmpAll(16'h0000, 1'b0, 1'b1, "return");
        check({3'h0, pcValue}, {3'h0, head}, "return address");
        check({15'h0000, insnReady}, 16'h0000, "return gap");
        @(negedge clk);
        check({15'h0000, insnReady}, 16'h0001, "return end");
      end
      default: begin
        issue(OP_SLEEP, r[31:24]);
        insnValid = 1'b0;
        mE = 1'b1;
        mP = 1'b0;
        cmpAll(16'h0000, 1'b1, 1'b0, "halt");
        repeat (3) @(negedge clk);
        check({14'h0000, oscStop, insnReady}, 16'h0002, "halted");
        wake = 1'b1;
        @(negedge clk);
        wake = 1'b0;
        check({14'h0000, oscStop, insnReady}, 16'h0001, "woken");
      end
    endcase
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Print counts and verdict, then stop
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Hang guard, far longer than the sequence needs
  initial begin
    #80000;
    miscompares++;
    $display("wrong value at %0t: run timed out", $time);
    report_and_stop();
  end

  // Main sequence
  initial begin
    logic [31:0] r;
    rst_n = 1'b0;
    {insnValid, callPush, wake} = 3'b000;
    insn = 14'h0000;
    pcPlusOne = 13'h0000;
    fileData = 8'h00;
    {mAcc, mC, mH, mZ, mE, mP} = {8'h00, 5'b00011};
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    cmpAll(16'h0000, 1'b0, 1'b0, "reset");
    $display("test reset done");
    // Boundaries: zero result, equal and borrowing subtraction
    doOp(0, 1'b1, mAcc);
    doOp(1, 1'b1, 8'h00);
    doOp(1, 1'b1, 8'h0F);
    doOp(1, 1'b1, 8'hFF);
    // Small literal under a large accumulator borrows from the top
    doOp(1, 1'b1, 8'h00);
    $display("test boundary done");
    // Random mix; a gap is left now and then, and the stack is kept within depth
    for (int i = 0; i < 400; i++) begin
      r = rnd();
      if (r[3] && stk.size() < STACK_DEPTH) push(r[28:16]);
      else if (r[4]) begin
        insnValid = 1'b0;
        @(negedge clk);
      end
      doOp(int'(r[10:8]) % 6, 1'b0, 8'h00);
    end
    insnValid = 1'b0;
    $display("test random done");
    report_and_stop();
  end
endmodule
